// *** hdl/gmq_frontend.sv ***
// message queue front end: input normaliser, output queue, error queue
`timescale 1ns/1ps
`default_nettype none

module gmq_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic flush, // drop all contents
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // read accept
  output logic [W-1:0] out_data, // oldest word
  output logic [$clog2(DEPTH+1)-1:0] count // words held
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [$clog2(DEPTH+1)-1:0] cnt_q, cnt_d;
  logic wr, rd;

  assign in_ready = (cnt_q != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign count = cnt_q;
  assign wr = in_valid && in_ready && !flush;
  assign rd = out_valid && out_ready && !flush;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end else begin
      if (wr) wp_d = (wp_q == LAST) ? '0 : AW'(wp_q + 1'b1);
      if (rd) rp_d = (rp_q == LAST) ? '0 : AW'(rp_q + 1'b1);
      if (wr && !rd) cnt_d = cnt_q + 1'b1;
      if (rd && !wr) cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      if (wr) mem_q[wp_q] <= in_data;
    end
  end
endmodule // gmq_fifo

// Notes on behaviour
// - each byte taken from the bus flushes the output queue.
// - bit 7 of every received byte is cleared before storage.
// - strings and blocks pass unchanged; elsewhere lower case becomes upper case.
// - outside strings and blocks, control codes other than line feed become spaces.
// - outside strings and blocks, runs of blanks collapse to one blank.
// - a byte with EOI is followed by one line feed, never two.
// - parser starts on a line feed stored outside strings and blocks, on EOI, or when the input queue fills.
// - device clear, interface clear or reset empty the input queue.
// - addressed as talker, the output queue is sent in order.
// - responses end with CR then LF, EOI on the LF.
// - output queue stays empty without a query or after a faulty one.
// - status bit 4 shows whether the output queue holds data.
// - error queue holds 30 codes, oldest read first.
// - an error code already queued is not queued again.
// - beyond 29 errors the overflow code -350 takes the last slot.
// - semicolons separate commands; line feed or EOI ends a message.
// - a number without unit takes the default unit; scaled units accepted.
// - short or long keywords accepted; a leading colon is optional.
// - numbers may be integer, decimal or exponential; strings quote-matched.
// - event status enable takes 0 to 255 and reads back so.
// - bus address resets to 24 and only the front panel changes it.
// - front panel local key restores local unless lockout is set.
// - full handshakes, service request, device clear; no poll, trigger, control.
module gmq_frontend #(
  parameter logic [15:0] ERR_RANGE = 16'hff00 // code posted for bad enable value
) (
  input wire logic clk, // 20 MHz system clock
  input wire logic rst_n, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic rx_valid, // acceptor has a byte
  output logic rx_ready_q, // byte may be taken
  input wire logic [7:0] rx_data, // received byte
  input wire logic rx_eoi, // byte came with EOI
  input wire logic dev_clear, // device clear pulse
  input wire logic ifc, // interface clear pulse
  output logic cmd_valid, // parser byte available
  input wire logic cmd_ready, // parser takes byte
  output logic [9:0] cmd_data, // {unit,raw,byte}
  output logic parse_start_q, // start parser pulse
  input wire logic resp_valid, // response byte
  output logic resp_ready_q, // response byte taken
  input wire logic [7:0] resp_data, // response data
  input wire logic resp_last, // last byte of response
  input wire logic resp_abort, // query had an error
  input wire logic talk_addr, // addressed to talk
  output logic tx_valid_q, // source has a byte
  input wire logic tx_ready, // source handshake done
  output logic [7:0] tx_data_q, // byte to send
  output logic tx_eoi_q, // send with EOI
  input wire logic [7:0] stb_src, // other status bits
  input wire logic [7:0] sre, // service request enable
  output logic [7:0] stb_q, // status byte
  output logic srq_q, // service request
  input wire logic err_post, // post an error code
  input wire logic [15:0] err_code, // code to post
  input wire logic err_pop, // remove oldest error
  input wire logic err_clear, // empty error queue
  output logic [15:0] err_head_q, // oldest error code
  output logic [4:0] err_cnt_q, // errors queued
  input wire logic ese_wr, // enable write
  input wire logic [15:0] ese_val, // enable value
  output logic [7:0] ese_q, // enable register
  input wire logic panel_addr_we, // front panel sets address
  input wire logic [4:0] panel_addr, // new address
  output logic [4:0] addr_q, // bus address
  input wire logic go_remote, // remote entered
  input wire logic ren, // remote enable level
  input wire logic llo, // local lockout level
  input wire logic panel_local, // local key pulse
  output logic remote_q // in remote state
);
  function automatic logic is_digit(input logic [7:0] b);
    return (b >= gmq_pkg::CH_0) && (b <= gmq_pkg::CH_9);
  endfunction

  function automatic logic is_upper(input logic [7:0] b);
    return (b >= gmq_pkg::CH_A_UP) && (b <= gmq_pkg::CH_Z_UP);
  endfunction

  function automatic logic [7:0] norm_char(input logic [7:0] b);
    if ((b >= gmq_pkg::CH_A_LO) && (b <= gmq_pkg::CH_Z_LO)) return b & ~gmq_pkg::CASE_BIT;
    if ((b <= gmq_pkg::CTRL_MAX) && (b != gmq_pkg::CH_LF)) return gmq_pkg::CH_SP;
    return b;
  endfunction

  logic iq_wv, iq_rdy, iq_flush, oq_wv, oq_rdy, oq_flush, oq_ov, oq_pop;
  logic [9:0] iq_wd;
  logic [8:0] oq_wd, oq_od;
  logic [4:0] iq_cnt, oq_cnt;

  gmq_fifo #(.W(gmq_pkg::IQ_W), .DEPTH(gmq_pkg::IQ_DEPTH)) u_iq (
    .clk(clk), .rst_n(rst_n), .ce(ce), .flush(iq_flush),
    .in_valid(iq_wv), .in_ready(iq_rdy), .in_data(iq_wd),
    .out_valid(cmd_valid), .out_ready(cmd_ready), .out_data(cmd_data), .count(iq_cnt)
  );

  gmq_fifo #(.W(gmq_pkg::OQ_W), .DEPTH(gmq_pkg::OQ_DEPTH)) u_oq (
    .clk(clk), .rst_n(rst_n), .ce(ce), .flush(oq_flush),
    .in_valid(oq_wv), .in_ready(oq_rdy), .in_data(oq_wd),
    .out_valid(oq_ov), .out_ready(oq_pop), .out_data(oq_od), .count(oq_cnt)
  );

  // input side
  gmq_pkg::gmq_scan_e sc_q, sc_d;
  logic hold_v_q, hold_v_d, hold_eoi_q, hold_eoi_d, pend_lf_q, pend_lf_d;
  logic [7:0] hold_b_q, hold_b_d, quote_q, quote_d;
  logic [3:0] ndig_q, ndig_d;
  logic [15:0] bcnt_q, bcnt_d;
  logic last_sp_q, last_sp_d, msg_start_q, msg_start_d, num_q, num_d;
  logic full_q, full_d, rx_ready_d, start_d, rx_take, clr;
  logic store, raw, unit;
  logic [7:0] b, m, sb;
  logic [15:0] bnext;

  assign rx_take = rx_valid && rx_ready_q;
  assign clr = dev_clear || ifc;

  always_comb begin
    sc_d = sc_q;
    hold_v_d = hold_v_q;
    hold_b_d = hold_b_q;
    hold_eoi_d = hold_eoi_q;
    pend_lf_d = pend_lf_q;
    quote_d = quote_q;
    ndig_d = ndig_q;
    bcnt_d = bcnt_q;
    last_sp_d = last_sp_q;
    msg_start_d = msg_start_q;
    num_d = num_q;
    start_d = 1'b0;
    iq_wv = 1'b0;
    iq_wd = '0;
    store = 1'b0;
    raw = 1'b1;
    unit = 1'b0;
    b = hold_b_q;
    m = norm_char(hold_b_q);
    sb = hold_b_q;
    bnext = 16'(bcnt_q * gmq_pkg::DEC_BASE + {8'h00, 8'(hold_b_q - gmq_pkg::CH_0)});
    iq_flush = 1'b0;
    if (pend_lf_q) begin
      if (iq_rdy) begin
        iq_wv = 1'b1;
        iq_wd = {2'b00, gmq_pkg::CH_LF};
        pend_lf_d = 1'b0;
        start_d = 1'b1;
      end
    end else if (hold_v_q && iq_rdy) begin
      hold_v_d = 1'b0;
      store = 1'b1;
      case (sc_q)
        gmq_pkg::SC_PLAIN: begin
          raw = 1'b0;
          sb = m;
          if ((b == gmq_pkg::CH_DQ) || (b == gmq_pkg::CH_SQ)) begin
            quote_d = b;
            sc_d = gmq_pkg::SC_STR;
            sb = b;
          end else if (b == gmq_pkg::CH_HASH) begin
            sc_d = gmq_pkg::SC_BHDR;
          end else if ((m == gmq_pkg::CH_SP) && last_sp_q) begin
            store = 1'b0;
          end else if ((m == gmq_pkg::CH_COLON) && msg_start_q) begin
            store = 1'b0;
          end
          // an E right after digits is an exponent, any other letter opens a unit
          unit = num_q && is_upper(m) && (m != gmq_pkg::CH_E_UP);
          num_d = is_digit(m) || (m == gmq_pkg::CH_DOT) || (num_q && (m == gmq_pkg::CH_E_UP));
          last_sp_d = (m == gmq_pkg::CH_SP);
          if (store && (m != gmq_pkg::CH_SP)) msg_start_d = 1'b0;
          if (m == gmq_pkg::CH_SEMI) num_d = 1'b0;
        end
        gmq_pkg::SC_STR: begin
          if (b == quote_q) sc_d = gmq_pkg::SC_PLAIN;
        end
        gmq_pkg::SC_BHDR: begin
          ndig_d = 4'(b - gmq_pkg::CH_0);
          bcnt_d = '0;
          if (!is_digit(b)) sc_d = gmq_pkg::SC_PLAIN;
          else if (b == gmq_pkg::CH_0) sc_d = gmq_pkg::SC_BINF;
          else sc_d = gmq_pkg::SC_BLEN;
        end
        gmq_pkg::SC_BLEN: begin
          bcnt_d = bnext;
          ndig_d = ndig_q - 1'b1;
          if (ndig_q == 4'h1) sc_d = (bnext == '0) ? gmq_pkg::SC_PLAIN : gmq_pkg::SC_BDAT;
        end
        gmq_pkg::SC_BDAT: begin
          bcnt_d = bcnt_q - 1'b1;
          if (bcnt_q == 16'h0001) sc_d = gmq_pkg::SC_PLAIN;
        end
        gmq_pkg::SC_BINF: begin
          sb = b;
        end
        default: sc_d = gmq_pkg::SC_PLAIN;
      endcase
      if (store) begin
        iq_wv = 1'b1;
        iq_wd = {unit, raw, sb};
      end
      if (store && (sb == gmq_pkg::CH_LF) && (sc_q == gmq_pkg::SC_PLAIN)) begin
        start_d = 1'b1;
        msg_start_d = 1'b1;
        num_d = 1'b0;
        last_sp_d = 1'b0;
      end
      if (hold_eoi_q) begin
        // eoi ends the message whatever the scanner was inside
        pend_lf_d = !(store && (sb == gmq_pkg::CH_LF));
        sc_d = gmq_pkg::SC_PLAIN;
        msg_start_d = 1'b1;
        num_d = 1'b0;
        last_sp_d = 1'b0;
        if (!pend_lf_d) start_d = 1'b1;
      end
    end
    if (rx_take) begin
      hold_v_d = 1'b1;
      hold_b_d = rx_data & gmq_pkg::MSB_MASK;
      hold_eoi_d = rx_eoi;
    end
    full_d = (iq_cnt == 5'(gmq_pkg::IQ_DEPTH));
    if (full_d && !full_q) start_d = 1'b1;
    if (clr) begin
      iq_flush = 1'b1;
      hold_v_d = 1'b0;
      pend_lf_d = 1'b0;
      sc_d = gmq_pkg::SC_PLAIN;
      msg_start_d = 1'b1;
      num_d = 1'b0;
      last_sp_d = 1'b0;
      start_d = 1'b0;
    end
    // one byte in flight keeps ready a plain flop; costs half the rate
    rx_ready_d = !hold_v_d && !pend_lf_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sc_q <= gmq_pkg::SC_PLAIN;
      hold_v_q <= 1'b0;
      hold_b_q <= '0;
      hold_eoi_q <= 1'b0;
      pend_lf_q <= 1'b0;
      quote_q <= '0;
      ndig_q <= '0;
      bcnt_q <= '0;
      last_sp_q <= 1'b0;
      msg_start_q <= 1'b1;
      num_q <= 1'b0;
      full_q <= 1'b0;
      rx_ready_q <= 1'b0;
      parse_start_q <= 1'b0;
    end else if (ce) begin
      sc_q <= sc_d;
      hold_v_q <= hold_v_d;
      hold_b_q <= hold_b_d;
      hold_eoi_q <= hold_eoi_d;
      pend_lf_q <= pend_lf_d;
      quote_q <= quote_d;
      ndig_q <= ndig_d;
      bcnt_q <= bcnt_d;
      last_sp_q <= last_sp_d;
      msg_start_q <= msg_start_d;
      num_q <= num_d;
      full_q <= full_d;
      rx_ready_q <= rx_ready_d;
      parse_start_q <= start_d;
    end
  end

  // output side
  gmq_pkg::gmq_ow_e ow_q, ow_d;
  logic resp_ready_d, resp_take, tx_valid_d, tx_eoi_d;
  logic [7:0] tx_data_d;

  assign resp_take = resp_valid && resp_ready_q;

  always_comb begin
    ow_d = ow_q;
    oq_wv = 1'b0;
    oq_wd = '0;
    oq_flush = rx_take || clr || resp_abort;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    tx_eoi_d = tx_eoi_q;
    oq_pop = 1'b0;
    if (resp_abort || clr) begin
      ow_d = gmq_pkg::OW_BODY;
    end else begin
      case (ow_q)
        gmq_pkg::OW_BODY: begin
          if (resp_take && !rx_take) begin
            oq_wv = 1'b1;
            oq_wd = {1'b0, resp_data};
            if (resp_last) ow_d = gmq_pkg::OW_CR;
          end
        end
        gmq_pkg::OW_CR: begin
          oq_wv = 1'b1;
          oq_wd = {1'b0, gmq_pkg::CH_CR};
          if (oq_rdy) ow_d = gmq_pkg::OW_LF;
        end
        gmq_pkg::OW_LF: begin
          oq_wv = 1'b1;
          oq_wd = {1'b1, gmq_pkg::CH_LF};
          if (oq_rdy) ow_d = gmq_pkg::OW_BODY;
        end
        default: ow_d = gmq_pkg::OW_BODY;
      endcase
    end
    if (tx_valid_q && tx_ready) tx_valid_d = 1'b0;
    if (talk_addr && oq_ov && !tx_valid_d && !oq_flush) begin
      oq_pop = 1'b1;
      tx_valid_d = 1'b1;
      tx_data_d = oq_od[7:0];
      tx_eoi_d = oq_od[8];
    end
    if (oq_flush) tx_valid_d = 1'b0;
    // ready from the count keeps one slot spare for the byte in flight
    resp_ready_d = (ow_d == gmq_pkg::OW_BODY) && (oq_cnt < 5'(gmq_pkg::OQ_DEPTH - 1));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ow_q <= gmq_pkg::OW_BODY;
      resp_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
      tx_eoi_q <= 1'b0;
    end else if (ce) begin
      ow_q <= ow_d;
      resp_ready_q <= resp_ready_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_eoi_q <= tx_eoi_d;
    end
  end

  // status, error queue, enable, address, remote
  logic [15:0] eq_q [gmq_pkg::EQ_DEPTH];
  logic [15:0] eq_d [gmq_pkg::EQ_DEPTH];
  logic [4:0] ecnt_d, ecnt_w;
  logic [7:0] stb_d, ese_d;
  logic [4:0] addr_d;
  logic remote_d, srq_d, post, dup;
  logic [15:0] pcode;

  always_comb begin
    stb_d = stb_src;
    stb_d[gmq_pkg::MAV_BIT] = oq_ov || tx_valid_q;
    stb_d[gmq_pkg::RQS_BIT] = 1'b0;
    srq_d = |(stb_d & sre);
    stb_d[gmq_pkg::RQS_BIT] = srq_d;
    ese_d = ese_q;
    post = err_post;
    pcode = err_code;
    if (ese_wr) begin
      if (ese_val <= gmq_pkg::ESE_MAX) begin
        ese_d = ese_val[7:0];
      end else if (!err_post) begin
        post = 1'b1;
        pcode = ERR_RANGE;
      end
    end
    eq_d = eq_q;
    ecnt_w = err_cnt_q;
    if (err_pop && (err_cnt_q != '0)) begin
      for (int i = 0; i < gmq_pkg::EQ_DEPTH - 1; i++) eq_d[i] = eq_q[i + 1];
      eq_d[gmq_pkg::EQ_DEPTH - 1] = '0;
      ecnt_w = err_cnt_q - 1'b1;
    end
    if (err_clear) ecnt_w = '0;
    dup = 1'b0;
    for (int i = 0; i < gmq_pkg::EQ_DEPTH; i++) begin
      if ((5'(i) < ecnt_w) && (eq_d[i] == pcode)) dup = 1'b1;
    end
    ecnt_d = ecnt_w;
    if (post && !dup && (ecnt_w < gmq_pkg::EQ_FULL)) begin
      eq_d[ecnt_w] = (ecnt_w == gmq_pkg::EQ_OVF_AT) ? gmq_pkg::ERR_OVERFLOW : pcode;
      ecnt_d = ecnt_w + 1'b1;
    end
    addr_d = panel_addr_we ? panel_addr : addr_q;
    remote_d = remote_q;
    if (go_remote) remote_d = 1'b1;
    if (panel_local && !llo) remote_d = 1'b0;
    if (!ren) remote_d = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stb_q <= '0;
      srq_q <= 1'b0;
      ese_q <= '0;
      err_cnt_q <= '0;
      err_head_q <= '0;
      for (int i = 0; i < gmq_pkg::EQ_DEPTH; i++) eq_q[i] <= '0;
      addr_q <= gmq_pkg::DEF_ADDR;
      remote_q <= 1'b0;
    end else if (ce) begin
      stb_q <= stb_d;
      srq_q <= srq_d;
      ese_q <= ese_d;
      err_cnt_q <= ecnt_d;
      err_head_q <= eq_d[0];
      eq_q <= eq_d;
      addr_q <= addr_d;
      remote_q <= remote_d;
    end
  end
endmodule // gmq_frontend

`default_nettype wire

// *** include/gmq_pkg.sv ***
// constants and state codes for the message queue front end
package gmq_pkg;
  localparam int unsigned IQ_DEPTH = 16;
  localparam int unsigned OQ_DEPTH = 16;
  localparam int unsigned IQ_W = 10;
  localparam int unsigned OQ_W = 9;
  localparam int unsigned EQ_DEPTH = 30;
  localparam logic [4:0] EQ_OVF_AT = 5'h1d;
  localparam logic [4:0] EQ_FULL = 5'h1e;
  localparam int unsigned ERR_W = 16;
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
  localparam logic [7:0] MSB_MASK = 8'h7f;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CTRL_MAX = 8'h1f;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_DQ = 8'h22;
  localparam logic [7:0] CH_SQ = 8'h27;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [7:0] CH_E_UP = 8'h45;
  localparam logic [7:0] CH_Z_UP = 8'h5a;
  localparam logic [7:0] CH_A_LO = 8'h61;
  localparam logic [7:0] CH_Z_LO = 8'h7a;
  localparam logic [15:0] DEC_BASE = 16'h000a;
  localparam logic [15:0] ESE_MAX = 16'h00ff;
  localparam logic [4:0] DEF_ADDR = 5'h18;
  localparam int unsigned MAV_BIT = 4;
  localparam int unsigned RQS_BIT = 6;
  typedef enum logic [5:0] {
    SC_PLAIN = 6'h01,
    SC_STR = 6'h02,
    SC_BHDR = 6'h04,
    SC_BLEN = 6'h08,
    SC_BDAT = 6'h10,
    SC_BINF = 6'h20
  } gmq_scan_e;
  typedef enum logic [2:0] {
    OW_BODY = 3'h1,
    OW_CR = 3'h2,
    OW_LF = 3'h4
  } gmq_ow_e;
endpackage

// *** verif/gmq_frontend_props.sv ***
// port assertions for the message queue front end
`timescale 1ns/1ps
`default_nettype none
module gmq_frontend_props (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic rx_valid, // offered
  input wire logic rx_ready_q, // taken
  input wire logic [7:0] rx_data, // byte
  input wire logic cmd_valid, // word
  input wire logic [9:0] cmd_data, // word
  input wire logic parse_start_q, // start
  input wire logic tx_valid_q, // tx
  input wire logic [7:0] tx_data_q, // tx
  input wire logic tx_eoi_q, // tx end
  input wire logic [7:0] stb_q, // status
  input wire logic [4:0] err_cnt_q, // errors
  input wire logic [4:0] addr_q, // address
  input wire logic ren, // remote en
  input wire logic llo, // lockout
  input wire logic remote_q // remote
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_msb_clear: assert property (cmd_valid |-> !cmd_data[7])
    else $error("bit 7 stored");
  chk_upper_case: assert property (cmd_valid && !cmd_data[8] |->
    !(cmd_data[7:0] inside {[8'h61:8'h7a]})) else $error("lower case stored");
  chk_ctrl_space: assert property (cmd_valid && !cmd_data[8] |->
    cmd_data[7:0] == 8'h0a || cmd_data[7:0] >= 8'h20) else $error("control code stored");
  chk_lf_start: assert property (rx_valid && rx_ready_q && rx_data[6:0] == 7'h0a |->
    ##2 parse_start_q) else $error("no parser start");
  chk_rx_flush: assert property (rx_valid && rx_ready_q |=> !tx_valid_q)
    else $error("output not flushed");
  chk_mav_set: assert property (tx_valid_q |=> stb_q[4])
    else $error("flag low with data");
  chk_eoi_lf: assert property (tx_valid_q && $rose(tx_eoi_q) |->
    tx_data_q == 8'h0a && $past(tx_data_q) == 8'h0d) else $error("end mark misplaced");
  chk_err_depth: assert property (err_cnt_q <= 5'd30)
    else $error("error queue too deep");
  chk_addr_reset: assert property ($rose(rst_n) |-> addr_q == 5'h18)
    else $error("address not 24");
  chk_lock_hold: assert property (remote_q && llo && ren |=> remote_q)
    else $error("remote left under lockout");
endmodule // gmq_frontend_props
bind gmq_frontend gmq_frontend_props u_props (.clk, .rst_n, .rx_valid, .rx_ready_q, .rx_data,
  .cmd_valid, .cmd_data, .parse_start_q, .tx_valid_q, .tx_data_q, .tx_eoi_q, .stb_q, .err_cnt_q,
  .addr_q, .ren, .llo, .remote_q);
`default_nettype wire

// *** verif/gmq_ctl_model.sv ***
// bus controller model: offers bytes and takes source bytes
`timescale 1ns/1ps
`default_nettype none
module gmq_ctl_model (
  input wire logic clk, // clock
  output logic rx_valid, // offered
  input wire logic rx_ready_q, // taken
  output logic [7:0] rx_data, // byte
  output logic rx_eoi, // end mark
  output logic talk_addr, // talker
  input wire logic tx_valid_q, // source byte
  output logic tx_ready, // accepted
  input wire logic [7:0] tx_data_q, // data
  input wire logic tx_eoi_q // end mark
);
  logic [8:0] got[$];
  logic hold = 0;
  logic [1:0] ph = 0;
  initial begin
    rx_valid = 0;
    rx_data = 8'h5a;
    rx_eoi = 0;
    talk_addr = 0;
    tx_ready = 0;
  end
  // one slow cycle in four so late acceptance is seen too
  always @(negedge clk) begin
    ph <= ph + 2'h1;
    tx_ready <= !hold && ph != 2'h3;
  end
  always @(posedge clk) if (tx_valid_q && tx_ready) got.push_back({tx_eoi_q, tx_data_q});
  task automatic send(input logic [7:0] b, input logic e);
    @(negedge clk);
    rx_valid = 1;
    rx_data = b;
    rx_eoi = e;
    do @(posedge clk); while (!rx_ready_q);
    @(negedge clk);
    rx_valid = 0;
    rx_data = ~b; // no stale value once released
    rx_eoi = ~e;
  endtask
endmodule // gmq_ctl_model
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the message queue front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] RNG = 16'h0e01; // arbitrary refused-value code
  logic clk = 0, rst_n = 0, dev_clear = 0, ifc = 0, cmd_ready = 0, pop_en = 1, seen = 0, in_s = 0;
  logic resp_valid = 0, resp_last = 0, resp_abort = 0, err_post = 0, err_pop = 0, err_clear = 0;
  logic ese_wr = 0, panel_addr_we = 0, go_remote = 0, llo = 0, panel_local = 0;
  logic rx_valid, rx_ready_q, rx_eoi, cmd_valid, parse_start_q, resp_ready_q, talk_addr, remote_q;
  logic tx_valid_q, tx_ready, tx_eoi_q, srq_q;
  logic [4:0] panel_addr = 0, err_cnt_q, addr_q;
  logic [7:0] resp_data = 0, rx_data, tx_data_q, stb_q, ese_q, last = 0, qch = 0, sre = 8'h10;
  logic [9:0] cmd_data, eq[$];
  logic [8:0] tq[$];
  logic [15:0] err_code = 0, ese_val = 0, err_head_q, ee[$];
  logic [31:0] xs = 32'd9909;
  int failures = 0, n_checks = 0, cyc = 0, i, k;
  logic [7:0] tbl[12] = '{8'h61, 8'h5a, 8'h35, 8'h20, 8'h01, 8'h09, 8'h0d, 8'he2, 8'h7a, 8'h0a,
    8'h78, 8'hb0};
  logic [7:0] str[11] = '{8'h61, 8'h27, 8'h62, 8'h20, 8'h20, 8'h63, 8'h01, 8'h22, 8'h27, 8'h64,
    8'h0a};
  gmq_frontend #(.ERR_RANGE(RNG)) uut (.clk, .rst_n, .ce(1'b1), .rx_valid, .rx_ready_q, .rx_data,
    .rx_eoi, .dev_clear, .ifc, .cmd_valid, .cmd_ready, .cmd_data, .parse_start_q, .resp_valid,
    .resp_ready_q, .resp_data, .resp_last, .resp_abort, .talk_addr, .tx_valid_q, .tx_ready,
    .tx_data_q, .tx_eoi_q, .stb_src(8'h00), .sre, .stb_q, .srq_q, .err_post, .err_code,
    .err_pop, .err_clear, .err_head_q, .err_cnt_q, .ese_wr, .ese_val, .ese_q, .panel_addr_we,
    .panel_addr, .addr_q, .go_remote, .ren(1'b1), .llo, .panel_local, .remote_q);
  gmq_ctl_model ctl (.clk, .rx_valid, .rx_ready_q, .rx_data, .rx_eoi, .talk_addr, .tx_valid_q,
    .tx_ready, .tx_data_q, .tx_eoi_q);
  function automatic logic [31:0] nx(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  // word: {compare raw, raw, byte}
  task automatic put(input logic [7:0] b, input logic [1:0] r);
    eq.push_back({r, b});
    last = b;
  endtask
  task automatic snd(input logic [7:0] b, input logic e);
    ctl.send(b, e);
    b &= 8'h7f;
    if (in_s && b != qch) put(b, 2'b11);
    else if (b == 8'h22 || b == 8'h27) begin
      put(b, 2'b00);
      in_s = !in_s;
      qch = b;
    end else begin
      if (b >= 8'h61 && b <= 8'h7a) b -= 8'h20;
      if (b < 8'h20 && b != 8'h0a) b = 8'h20;
      if (b != 8'h20 || last != 8'h20) put(b, 2'b10);
    end
    if (e && b != 8'h0a) put(8'h0a, 2'b10);
  endtask
  task automatic drain();
    pop_en = 1;
    for (k = 0; k < 3000 && eq.size() > 0; k++) @(negedge clk);
    chk("drained", 16'(eq.size()), 16'h0);
  endtask
  task automatic rsp(input int n, input logic fin);
    for (int j = 0; j < n; j++) begin
      @(negedge clk);
      resp_valid = 1;
      resp_data = xs[7:0];
      resp_last = fin && j == n - 1;
      do @(posedge clk); while (!resp_ready_q);
      tq.push_back({1'b0, resp_data});
    end
    @(negedge clk);
    resp_valid = 0;
    resp_last = 0;
    resp_data = ~resp_data;
    if (fin) tq = {tq, 9'h00d, 9'h10a};
  endtask
  task automatic talk();
    ctl.talk_addr = 1;
    for (k = 0; k < 500 && ctl.got.size() < tq.size(); k++) @(negedge clk);
    repeat (8) @(negedge clk);
    ctl.talk_addr = 0;
    chk("tx count", 16'(ctl.got.size()), 16'(tq.size()));
    foreach (tq[j])
      if (j < ctl.got.size()) chk("tx byte", {7'h0, ctl.got[j]}, {7'h0, tq[j]});
    repeat (3) @(negedge clk);
    chk("flag clear", {15'h0, stb_q[4]}, 16'h0);
    tq.delete();
    ctl.got.delete();
  endtask
  task automatic post(input logic [15:0] c);
    @(negedge clk);
    err_post = 1;
    err_code = c;
    @(negedge clk);
    err_post = 0;
    if (!(c inside {ee}) && ee.size() < 30) ee.push_back(ee.size() == 29 ? -16'd350 : c);
  endtask
  always #25 clk = ~clk;
  always @(negedge clk) begin
    xs = nx(xs);
    cmd_ready <= pop_en & |xs[4:3];
  end
  always @(posedge clk) begin
    cyc++;
    if (parse_start_q) seen = 1;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
    if (rst_n && cmd_valid && cmd_ready) begin
      chk("word byte", {8'h0, cmd_data[7:0]}, {8'h0, eq[0][7:0]});
      if (eq[0][9]) chk("word raw", {15'h0, cmd_data[8]}, {15'h0, eq[0][8]});
      if (eq.size() > 0) void'(eq.pop_front());
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    chk("addr reset", {11'h0, addr_q}, 16'h0018);
    for (i = 0; i < 300; i++) snd(tbl[xs % 12], xs[9:5] == 5'h0);
    snd(8'h41, 1);
    snd(8'h0a, 1);
    foreach (str[j]) snd(str[j], 0);
    drain();
    $display("normalise test done");
    pop_en = 0;
    repeat (4) @(negedge clk);
    seen = 0;
    for (i = 0; i < 16; i++) snd(8'h41 + 8'(i), 0);
    snd(8'h51, 0);
    repeat (4) @(negedge clk);
    chk("full refuses", {15'h0, rx_ready_q}, 16'h0);
    chk("full starts", {15'h0, seen}, 16'h1);
    drain();
    pop_en = 0;
    for (int j = 0; j < 2; j++) begin
      snd(8'h42, 0);
      repeat (3) @(negedge clk);
      if (j == 0) pulse(dev_clear);
      else pulse(ifc);
      eq.delete();
      repeat (2) @(negedge clk);
      chk("cleared", {15'h0, cmd_valid}, 16'h0);
    end
    pop_en = 1;
    $display("queue test done");
    rsp(3, 1);
    rsp(1, 1);
    repeat (4) @(negedge clk);
    chk("flag set", {15'h0, stb_q[4]}, 16'h1);
    chk("srq", {15'h0, srq_q}, 16'h1);
    talk();
    rsp(2, 1);
    ctl.hold = 1;
    ctl.talk_addr = 1;
    repeat (4) @(negedge clk);
    snd(8'h20, 0);
    tq.delete();
    ctl.hold = 0;
    talk();
    rsp(2, 0);
    pulse(resp_abort);
    tq.delete();
    talk();
    $display("output test done");
    for (int j = 0; j < 2; j++) begin
      ese_val = j ? 16'h0100 : 16'h00ff;
      pulse(ese_wr);
      repeat (2) @(negedge clk);
      chk("enable", {8'h0, ese_q}, 16'h00ff);
    end
    chk("range code", err_head_q, RNG);
    pulse(err_clear);
    for (i = 0; i < 34; i++) post(i == 4 ? 16'h0102 : 16'h0100 + 16'(i));
    repeat (2) @(negedge clk);
    chk("err count", {11'h0, err_cnt_q}, 16'(ee.size()));
    while (ee.size() > 0) begin
      chk("err head", err_head_q, ee.pop_front());
      pulse(err_pop);
      @(negedge clk);
    end
    $display("error test done");
    panel_addr = 5'h03;
    pulse(panel_addr_we);
    @(negedge clk);
    chk("addr", {11'h0, addr_q}, 16'h0003);
    pulse(go_remote);
    llo = 1;
    pulse(panel_local);
    @(negedge clk);
    chk("lockout", {15'h0, remote_q}, 16'h1);
    llo = 0;
    pulse(panel_local);
    @(negedge clk);
    chk("local", {15'h0, remote_q}, 16'h0);
    $display("panel test done");
    complete_run();
  end
endmodule // tb
`default_nettype wire
